// [verilog/dma_enable_halt_control.sv]
/*
  Enable, halt, resume and abort control of one full-address DMA
  channel pair. Assumes a 10 MHz clock, a plain register port, a
  trigger pulse from an on-chip peripheral and an NMI pin.
*/
// Summary of operation
// - Halted channel blocks trigger CPU interrupt
// - Clearing transfer enable releases trigger interrupt
// - NMI in full address mode finishes unit, clears master enable, halts
// - Block counter keeps count after halt
// - Mid-block halt clears trigger flag, no pending
// - Halted channel clears trigger flag, starts no transfer
// - Resume waits trigger, finishes block remainder
// - Memory address 20 or 24 bits by mode
// - I/O address confined to top 256 bytes
// - Abort dead cycle leaves address, counters
// - Run only with both enables set in full address mode
// - Clearing transfer enable stops after unit
// - End interrupt when enable clear, ignores master
`timescale 1ns/1ps
`default_nettype none
module dma_enable_halt_control
  import dma_ctl_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [23:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [23:0] o_rdata,
  input  wire logic        i_nmi,
  input  wire logic        i_trig,
  input  wire logic        i_bus_done,
  output logic             o_bus_req,
  output logic             o_dead_cycle,
  output logic      [23:0] o_src_addr,
  output logic      [23:0] o_dst_addr,
  output logic             o_cpu_trig_irq,
  output logic             o_trig_flag_clr,
  output logic             o_end_irq,
  output logic             o_irq
);
  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic              rst_n;
  logic [3:0]        ctl_a_q;
  logic [1:0]        ctl_b_q;
  logic              m16_q;
  logic [23:0]       mar_q;
  logic [7:0]        io_address_reg_q;
  logic [7:0]        blk_init_q;
  logic [7:0]        blk_cnt_q;
  logic [15:0]       xfer_cnt_q;
  logic [S_W-1:0]    stat_q;
  logic [S_W-1:0]    ien_q;
  logic              nmi_m_q;
  logic              nmi_s_q;
  logic              nmi_p_q;
  logic              pend_q;
  dstate_t           st_q;
  dstate_t           st_d;

  dma_reset_sync u_rst (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .o_rst_n   (rst_n)
  );

  // ------------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------------
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction

  wire w_ca    = i_wr && hit(i_addr, A_CTRL_FIRST);
  wire w_cb    = i_wr && hit(i_addr, A_CTRL_SECOND);
  wire te      = ctl_a_q[B_TE];
  wire me      = ctl_b_q[B_ME];
  wire full    = ctl_b_q[B_FULL];
  wire blkmode = ctl_a_q[B_BLK];
  // Channel runs only with both enables set in full address mode
  // both enables gate in full address mode, transfer enable alone otherwise
  wire run     = te && (me || !full);
  wire halted  = te && !me && full;
  wire nmi_rise = nmi_s_q && !nmi_p_q;
  wire nmi_hit = nmi_rise && full;
  wire trig_ok = i_trig && run;
  wire xfer_end = (st_q == ST_XFER) && i_bus_done;
  wire last_unit = xfer_end && (xfer_cnt_q == CNT_ONE);
  wire blk_last = !blkmode || (blk_cnt_q == BLK_ONE);
  wire stop_now = !run || nmi_hit;
  // Memory address masked in 1-Mbyte mode
  // address span by mode
  wire [23:0] mar_eff = m16_q ? mar_q : (mar_q & MASK_1M);
  wire [23:0] io_eff = (m16_q ? IO_BASE16 : IO_BASE1M)
                       | ({16'h0000, io_address_reg_q} & IO_LOW);
  wire [23:0] mar_step = ctl_a_q[B_WORD] ? 24'h000002 : 24'h000001;
  wire [S_W-1:0] ev = {st_q == ST_DEAD, nmi_hit, last_unit};

  // ------------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (pend_q && run) st_d = ST_XFER;
      end
      ST_XFER: begin
        if (i_bus_done) begin
          if (stop_now) st_d = ST_IDLE;
          else if (last_unit || blk_last) st_d = ST_IDLE;
        end
      end
      ST_DEAD: st_d = ST_IDLE;
    endcase
    // dead cycle on abort with pending
    if (st_q == ST_IDLE && pend_q && stop_now) st_d = ST_DEAD;
  end

  // NMI pin synchroniser and edge history
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_m_q <= 1'b0;
      nmi_s_q <= 1'b0;
      nmi_p_q <= 1'b0;
    end else begin
      nmi_m_q <= i_nmi;
      nmi_s_q <= nmi_m_q;
      nmi_p_q <= nmi_s_q;
    end
  end

  // Control registers; NMI clears master enable over software
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_a_q <= 4'h0;
      ctl_b_q <= 2'h0;
      m16_q   <= 1'b0;
      io_address_reg_q  <= 8'h00;
      ien_q   <= '0;
      blk_init_q <= 8'h00;
    end else begin
      if (w_ca) ctl_a_q <= i_wdata[3:0];
      else if (last_unit) ctl_a_q[B_TE] <= 1'b0;
      if (w_cb) ctl_b_q <= i_wdata[1:0];
      if (nmi_hit) ctl_b_q[B_ME] <= 1'b0;
      if (i_wr && hit(i_addr, A_MODE)) m16_q <= i_wdata[B_M16];
      if (i_wr && hit(i_addr, A_IO_ADDR)) io_address_reg_q <= i_wdata[7:0];
      if (i_wr && hit(i_addr, A_IRQ_EN)) ien_q <= i_wdata[S_W-1:0];
      if (i_wr && hit(i_addr, A_BLK_INIT)) blk_init_q <= i_wdata[7:0];
    end
  end

  // Pending request, state and counters
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= ST_IDLE;
      pend_q     <= 1'b0;
      mar_q      <= 24'h000000;
      blk_cnt_q  <= 8'h00;
      xfer_cnt_q <= CNT_ZERO;
    end else begin
      st_q <= st_d;
      if (trig_ok) pend_q <= 1'b1;
      else if (stop_now || xfer_end && (blk_last || last_unit))
        pend_q <= 1'b0;
      if (i_wr && hit(i_addr, A_MEM_ADDR)) mar_q <= i_wdata;
      else if (xfer_end) mar_q <= mar_q + mar_step;
      if (i_wr && hit(i_addr, A_XFER_CNT)) xfer_cnt_q <= i_wdata[15:0];
      else if (xfer_end) xfer_cnt_q <= xfer_cnt_q - CNT_ONE;
      if (i_wr && hit(i_addr, A_BLK_CNT)) blk_cnt_q <= i_wdata[7:0];
      else if (xfer_end && blkmode)
        blk_cnt_q <= blk_last ? blk_init_q : blk_cnt_q - BLK_ONE;
    end
  end

  // Sticky status; event wins over clear
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= '0;
    end else begin
      if (i_wr && hit(i_addr, A_IRQ_CLR))
        stat_q <= (stat_q & ~i_wdata[S_W-1:0]) | ev;
      else
        stat_q <= stat_q | ev;
    end
  end

  // Outputs and read data
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata         <= 24'h000000;
      o_bus_req       <= 1'b0;
      o_dead_cycle    <= 1'b0;
      o_src_addr      <= 24'h000000;
      o_dst_addr      <= 24'h000000;
      o_cpu_trig_irq  <= 1'b0;
      o_trig_flag_clr <= 1'b0;
      o_end_irq       <= 1'b0;
      o_irq           <= 1'b0;
    end else begin
      o_bus_req    <= (st_d == ST_XFER);
      o_dead_cycle <= (st_d == ST_DEAD);
      o_src_addr   <= mar_eff;
      o_dst_addr   <= io_eff;
      // trigger irq passes when transfer enable clear
      o_cpu_trig_irq <= i_trig && !te;
      o_trig_flag_clr <= (i_trig && te) ||
                         (nmi_hit && st_q != ST_XFER && blkmode &&
                          blk_cnt_q != blk_init_q) ||
                         (xfer_end && halted && blkmode && !blk_last);
      o_end_irq <= !te && ctl_a_q[B_EIE];
      o_irq     <= |(stat_q & ien_q);
      o_rdata   <= 24'h000000;
      if (i_rd) begin
        unique case (i_addr)
          A_CTRL_FIRST:  o_rdata <= {20'h00000, ctl_a_q};
          A_CTRL_SECOND: o_rdata <= {22'h000000, ctl_b_q};
          A_MEM_ADDR:    o_rdata <= mar_q;
          A_IO_ADDR:     o_rdata <= io_eff;
          A_BLK_INIT:    o_rdata <= {16'h0000, blk_init_q};
          A_BLK_CNT:     o_rdata <= {16'h0000, blk_cnt_q};
          A_XFER_CNT:    o_rdata <= {8'h00, xfer_cnt_q};
          A_STATUS:      o_rdata <= {21'h000000, stat_q};
          A_IRQ_EN:      o_rdata <= {21'h000000, ien_q};
          A_MODE:        o_rdata <= {23'h000000, m16_q};
          default:       o_rdata <= 24'h000000;
        endcase
      end
    end
  end
endmodule // dma_enable_halt_control
`default_nettype wire

// [pkg/dma_ctl_pkg.sv]
/*
  Constants shared by the DMA enable and halt control block.
  Assumes a single 10 MHz system clock and a simple register port.
*/
`default_nettype none
package dma_ctl_pkg;
  // ------------------------------------------------------------------
  // Register map (word offsets on the plain register port)
  // ------------------------------------------------------------------
  localparam logic [3:0] A_CTRL_FIRST  = 4'h0;
  localparam logic [3:0] A_CTRL_SECOND = 4'h1;
  localparam logic [3:0] A_MEM_ADDR    = 4'h2;
  localparam logic [3:0] A_IO_ADDR     = 4'h3;
  localparam logic [3:0] A_BLK_INIT    = 4'h4;
  localparam logic [3:0] A_BLK_CNT     = 4'h5;
  localparam logic [3:0] A_XFER_CNT    = 4'h6;
  localparam logic [3:0] A_STATUS      = 4'h7;
  localparam logic [3:0] A_IRQ_EN      = 4'h8;
  localparam logic [3:0] A_IRQ_CLR     = 4'h9;
  localparam logic [3:0] A_MODE        = 4'hA;

  // ------------------------------------------------------------------
  // Control field positions (first control register)
  // ------------------------------------------------------------------
  localparam int B_TE   = 0;  // transfer_enable_bit
  localparam int B_EIE  = 1;  // end_interrupt_enable
  localparam int B_BLK  = 2;  // block transfer mode
  localparam int B_WORD = 3;  // word size
  // Second control register
  localparam int B_ME   = 0;  // master_enable_bit
  localparam int B_FULL = 1;  // full address mode
  // Mode register
  localparam int B_M16  = 0;  // 16-Mbyte mode

  // ------------------------------------------------------------------
  // Address ranges and counter constants
  // ------------------------------------------------------------------
  localparam int          AW        = 24;
  localparam logic [23:0] MASK_1M   = 24'h0FFFFF;
  localparam logic [23:0] IO_BASE1M = 24'h0FFF00;
  localparam logic [23:0] IO_BASE16 = 24'hFFFF00;
  localparam logic [23:0] IO_LOW    = 24'h0000FF;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam logic [7:0]  BLK_ONE   = 8'h01;

  // Status bits
  localparam int S_END  = 0;
  localparam int S_HALT = 1;
  localparam int S_DEAD = 2;
  localparam int S_W    = 3;

  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_DEAD} dstate_t;
endpackage
`default_nettype wire

// [verilog/dma_reset_sync.sv]
/*
  Reset release synchroniser.
  Assumes an asynchronous active-low reset from the chip.
*/
`timescale 1ns/1ps
`default_nettype none
module dma_reset_sync (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  output logic      o_rst_n
);
  logic meta_q;

  // Two-stage release, asserted at once
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q  <= 1'b0;
      o_rst_n <= 1'b0;
    end else begin
      meta_q  <= 1'b1;
      o_rst_n <= meta_q;
    end
  end
endmodule // dma_reset_sync
`default_nettype wire

// [testbench/dma_ctl_properties.sv]
/*
  Port checker of the DMA enable and halt control.
  Assumes binding to the top module and its single clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dma_ctl_properties
  import dma_ctl_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic [3:0]  i_addr,
  input wire logic [23:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [23:0] o_rdata,
  input wire logic        i_trig,
  input wire logic        i_bus_done,
  input wire logic        o_bus_req,
  input wire logic        o_dead_cycle,
  input wire logic [23:0] o_src_addr,
  input wire logic [23:0] o_dst_addr,
  input wire logic        o_cpu_trig_irq,
  input wire logic        o_trig_flag_clr,
  input wire logic        o_end_irq
);
  // ------------------------------------------------------------
  // Mode shadow and assertions
  // ------------------------------------------------------------
  logic m16_q;

  // Follows software writes of the mode bit
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) m16_q <= 1'b0;
    else if (i_wr && i_addr == A_MODE) m16_q <= i_wdata[B_M16];
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  chk_src_narrow: assert property (o_bus_req && !m16_q
    |-> o_src_addr[23:20] == 4'h0) else $error("memory address too wide");
  chk_io_top: assert property (o_bus_req |-> o_dst_addr[23:8] ==
    (m16_q ? 16'hFFFF : 16'h0FFF)) else $error("io address out of range");
  chk_dead_keeps: assert property (o_dead_cycle |=>
    $stable(o_src_addr) && $stable(o_dst_addr)) else $error("dead moved");
  chk_dead_single: assert property (o_dead_cycle |=>
    !o_dead_cycle) else $error("dead cycle too long");
  chk_unit_holds: assert property (o_bus_req && !i_bus_done
    |=> o_bus_req) else $error("unit cut short");
  chk_start_end_low: assert property ($rose(o_bus_req)
    |-> !o_end_irq) else $error("end irq while starting");
  chk_fwd_cause: assert property ($rose(o_cpu_trig_irq)
    |-> $past(i_trig) || $past(i_trig, 2)) else $error("irq without trigger");
  chk_clr_pulse: assert property (o_trig_flag_clr
    |=> !o_trig_flag_clr) else $error("flag clear too long");
  chk_rdata_quiet: assert property (!$past(i_rd)
    |-> o_rdata == 24'h000000) else $error("read data outside slot");
endmodule // dma_ctl_properties

bind dma_enable_halt_control dma_ctl_properties u_props (.i_sys_clk,
  .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_trig,
  .i_bus_done, .o_bus_req, .o_dead_cycle, .o_src_addr, .o_dst_addr,
  .o_cpu_trig_irq, .o_trig_flag_clr, .o_end_irq);
`default_nettype wire

// [testbench/dma_far_side_model.sv]
/*
  Far side model: trigger peripheral and bus completion.
  Assumes the design's clock and its bus request level.
*/
`timescale 1ns/1ps
`default_nettype none
module dma_far_side_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_fire,
  input  wire logic [3:0] i_delay,
  input  wire logic       i_bus_req,
  output logic            o_trig,
  output logic            o_bus_done
);
  logic [4:0] cnt_q;

  // Fires on command, never while a unit runs
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_trig <= 1'b0;
    else o_trig <= i_fire && !i_bus_req && !o_trig;
  end

  // Ends each unit after i_delay cycles, then rests two
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q      <= 5'h00;
      o_bus_done <= 1'b0;
    end else if (i_bus_req && cnt_q == {1'b0, i_delay}) begin
      cnt_q      <= 5'h1E;
      o_bus_done <= 1'b1;
    end else begin
      o_bus_done <= 1'b0;
      if (i_bus_req || cnt_q[4]) cnt_q <= cnt_q + 5'h01;
    end
  end
endmodule // dma_far_side_model
`default_nettype wire

// [testbench/dma_enable_halt_control_tb_top.sv]
/*
  Bench of the DMA enable and halt control.
  Assumes the far side model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module dma_enable_halt_control_tb_top;
  import dma_ctl_pkg::*;
  typedef struct packed {logic [23:0] c1; logic [23:0] c2; logic e;} row_t;
  logic        clk, rst_n, wr, rd, nmi, fire, trig, bdone;
  logic        req, cirq, fclr, eirq, irq, seen;
  logic [3:0]  addr, dly;
  logic [23:0] wd, rdat, src, dst, v;
  int          n_fail, samples_checked, k;
  row_t        rows [4];

  dma_enable_halt_control dut (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
    .i_nmi(nmi), .i_trig(trig), .i_bus_done(bdone), .o_bus_req(req),
    .o_dead_cycle(), .o_src_addr(src), .o_dst_addr(dst),
    .o_cpu_trig_irq(cirq), .o_trig_flag_clr(fclr), .o_end_irq(eirq),
    .o_irq(irq));
  dma_far_side_model far (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_fire(fire), .i_delay(dly), .i_bus_req(req), .o_trig(trig),
    .o_bus_done(bdone));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [23:0] s, input logic [23:0] x);
    samples_checked++;
    if (s !== x) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, x);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic kick();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1 seen = seen | cirq | (req & !nmi) | (nmi & fclr);
    end
  endtask
  task automatic wait_req(input logic l);
    k = 0;
    while (req !== l && k < 200) begin
      @(posedge clk);
      #1 k++;
    end
    chk({23'h0, req}, {23'h0, l});
  endtask
  task automatic conclude();
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #3000000;
    n_fail++;
    conclude();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, wr, rd, nmi, fire} = 5'h00;
    addr = 4'h0;
    wd = 24'h0;
    dly = 4'h1;
    n_fail = 0;
    samples_checked = 0;
    rows = '{{24'h2, 24'h2, 1'b1}, {24'h2, 24'h3, 1'b1},
             {24'h3, 24'h2, 1'b0}, {24'h0, 24'h3, 1'b0}};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wr_reg(A_XFER_CNT, 24'h2);
    foreach (rows[i]) begin
      wr_reg(A_CTRL_FIRST, rows[i].c1);
      wr_reg(A_CTRL_SECOND, rows[i].c2);
      rd_reg(A_CTRL_SECOND);
      chk(v, rows[i].c2 & 24'h3);
      settle();
      chk({23'h0, eirq}, {23'h0, rows[i].e});
    end
    rd_reg(4'hF);
    chk(v, 24'h0);
    wr_reg(A_CTRL_SECOND, 24'h2);
    wr_reg(A_CTRL_FIRST, 24'h1);
    kick();
    watch(10);
    chk({23'h0, seen}, 24'h0);
    wr_reg(A_CTRL_FIRST, 24'h0);
    kick();
    watch(10);
    chk({23'h0, seen}, 24'h1);
    wr_reg(A_CTRL_SECOND, 24'h3);
    for (int m = 0; m < 2; m++) begin
      wr_reg(A_MODE, 24'(m));
      wr_reg(A_MEM_ADDR, 24'hABCDE0);
      wr_reg(A_IO_ADDR, 24'h5A);
      wr_reg(A_XFER_CNT, 24'h1);
      wr_reg(A_IRQ_EN, 24'h1);
      wr_reg(A_CTRL_FIRST, 24'h3);
      watch(10);
      chk({23'h0, seen}, 24'h0);
      kick();
      wait_req(1'b1);
      chk(src, m ? 24'hABCDE0 : 24'h0BCDE0);
      chk(dst, m ? 24'hFFFF5A : 24'h0FFF5A);
      wait_req(1'b0);
      settle();
      chk({23'h0, eirq & irq}, 24'h1);
      wr_reg(A_IRQ_EN, 24'h0);
      settle();
      chk({23'h0, irq}, 24'h0);
      wr_reg(A_IRQ_EN, 24'h1);
      settle();
      chk({23'h0, irq}, 24'h1);
      wr_reg(A_IRQ_CLR, 24'h1);
      settle();
      chk({23'h0, irq}, 24'h0);
    end
    wr_reg(A_BLK_INIT, 24'h4);
    wr_reg(A_BLK_CNT, 24'h4);
    wr_reg(A_XFER_CNT, 24'h2);
    wr_reg(A_CTRL_FIRST, 24'h5);
    dly <= 4'h8;
    kick();
    wait_req(1'b1);
    nmi <= 1'b1;
    watch(30);
    chk({23'h0, seen}, 24'h1);
    nmi <= 1'b0;
    chk({23'h0, req}, 24'h0);
    rd_reg(A_CTRL_SECOND);
    chk(v, 24'h2);
    rd_reg(A_BLK_CNT);
    chk(v, 24'h3);
    kick();
    watch(10);
    chk({23'h0, seen}, 24'h0);
    // master enable set, then a fresh trigger starts the transfer
    wr_reg(A_CTRL_SECOND, 24'h3);
    kick();
    wait_req(1'b1);
    wr_reg(A_CTRL_FIRST, 24'h4);
    wait_req(1'b0);
    watch(10);
    chk({23'h0, seen}, 24'h0);
    conclude();
  end
endmodule // dma_enable_halt_control_tb_top
`default_nettype wire
